// ===== hdl/csdec_params.svh
// constants for the chip-select address decoder
// Behaviour
// R01: address register holds one 16-bit base field
// R02: base compared with access address bits 31..16
// R03: regions start on 64 Kbyte boundaries only
// R04: 32-bit mask register carries 16-bit block mask
// R05: block mask applied bitwise, even non-contiguous
// R06: software keeps regions at most 4 MBytes
// R07: write-protected region aborts writes, allows reads
// R08: five access-space mask bits block when set
// R09: qualify bit clear: dma ignores space masks
// R10: qualify bit set: dma obeys space masks
// R11: selects one and two follow their valid bit
// R12: select zero invalid means boot select mode
// R13: select zero valid bit sticky until reset
// R14: selects one, two need select zero valid
// R15: software writes valid bit register last
// R16: three selects, each with own registers
// R17: active-low select driven low on region hit
// R18: select needs valid, match and qualification
`ifndef CSDEC_PARAMS_SVH
`define CSDEC_PARAMS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define CSD_REG_FIRST 8'h80
`define CSD_REG_STRIDE 8'h0C
`define CSD_OFS_ADDR 8'h00
`define CSD_OFS_MASK 8'h04
`define CSD_OFS_CTRL 8'h08
`define CSD_REG_STATUS 8'hA4

// ----------------------------------------
// field positions
// ----------------------------------------
`define CSD_BASE_LSB 16
`define CSD_BLOCK_MASK_LSB 16
`define CSD_WRITE_PROTECT_BIT 8
`define CSD_ALT_QUALIFY_BIT 6
`define CSD_SPACE_LSB 1
`define CSD_VALID_BIT 0
`define CSD_ST_BOOT_BIT 0
`define CSD_ST_SEL_LSB 1
`define CSD_ST_ABORT_BIT 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define CSD_BASE_RST 16'h0000
`define CSD_BLOCK_MASK_RST 16'h0000
`define CSD_SPACE_RST 5'h00
`define CSD_CTRL_RST 16'h0000
`define CSD_DATA_ZERO 32'h0000_0000

`endif

// ===== hdl/csdec_pkg.sv
// types shared by the chip-select address decoder
package csdec_pkg;

    // one-hot access space, bit order equals the mask field order
    typedef enum logic [4:0] {
        SPACE_USER_DATA = 5'b00001,
        SPACE_USER_CODE = 5'b00010,
        SPACE_SUPV_DATA = 5'b00100,
        SPACE_SUPV_CODE = 5'b01000,
        SPACE_CPU_IACK = 5'b10000
    } csdec_space_t;

    typedef struct packed {
        logic [15:0] base;
        logic [15:0] blockMask;
        logic writeProtect;
        logic altQualify;
        logic [4:0] spaceMask;
        logic valid;
    } csdec_cfg_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic write;
        logic dma;
        csdec_space_t space;
    } csdec_acc_t;

    typedef enum logic [2:0] {
        KIND_ADDR = 3'b001,
        KIND_MASK = 3'b010,
        KIND_CTRL = 3'b100
    } csdec_kind_t;

    typedef struct packed {
        logic hit;
        logic [1:0] index;
        csdec_kind_t kind;
    } csdec_dec_t;

endpackage

// ===== hdl/csdec_match.sv
// one chip select's region match and access qualification
`timescale 1ns/1ps
module csdec_match #(
    parameter bit BOOT_CAPABLE = 1'b0
) (
    // configuration
    input wire csdec_pkg::csdec_cfg_t cfg,
    input wire logic zeroValid,
    // access
    input wire csdec_pkg::csdec_acc_t acc,
    // result
    output logic hit,
    output logic protHit
);
    logic addrHit;
    logic spaceOk;
    logic qualOk;

    // low 16 address bits never enter the compare, so 64K granularity
    assign addrHit = ((acc.addr[31:16] ^ cfg.base) & ~cfg.blockMask) == 16'h0000; // R02 R03 R05
    assign spaceOk = (cfg.spaceMask & acc.space) == 5'h00; // R08
    assign qualOk = acc.dma ? (~cfg.altQualify | spaceOk) : spaceOk; // R09 R10

    always_comb begin
        if (BOOT_CAPABLE && !cfg.valid) begin
            // boot select answers every access until validated
            hit = acc.valid; // R12
            protHit = 1'b0;
        end else begin
            hit = acc.valid & cfg.valid & zeroValid & addrHit & qualOk; // R11 R14 R18
            protHit = hit & acc.write & cfg.writeProtect; // R07
        end
    end
endmodule // csdec_match

// ===== hdl/csdec_top.sv
// chip-select address decoder with Avalon-MM register slave
`timescale 1ns/1ps
`include "csdec_params.svh"
module csdec_top #(
    parameter int NUM_SEL = 3,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register bus
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // internal access
    input wire csdec_pkg::csdec_acc_t accReq,
    // external selects
    output logic selectZeroN,
    output logic selectOneN,
    output logic selectTwoN,
    // status
    output logic dataAbort,
    output logic bootMode
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] mergeBytes(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = oldVal;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = newVal[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [ADDR_W-1:0] regAddr(
        input int idx,
        input logic [7:0] ofs
    );
        logic [31:0] full;
        full = 32'(`CSD_REG_FIRST) + 32'(idx) * 32'(`CSD_REG_STRIDE) + 32'(ofs);
        return full[ADDR_W-1:0];
    endfunction

    // addresses outside the table decode as a miss
    function automatic csdec_pkg::csdec_dec_t decodeAddr(
        input logic [ADDR_W-1:0] a
    );
        csdec_pkg::csdec_dec_t d;
        d.hit = 1'b0;
        d.index = 2'h0;
        d.kind = csdec_pkg::KIND_ADDR;
        for (int i = 0; i < NUM_SEL; i++) begin
            if (a == regAddr(i, `CSD_OFS_ADDR)) begin
                d.hit = 1'b1;
                d.index = 2'(i);
                d.kind = csdec_pkg::KIND_ADDR;
            end else if (a == regAddr(i, `CSD_OFS_MASK)) begin
                d.hit = 1'b1;
                d.index = 2'(i);
                d.kind = csdec_pkg::KIND_MASK;
            end else if (a == regAddr(i, `CSD_OFS_CTRL)) begin
                d.hit = 1'b1;
                d.index = 2'(i);
                d.kind = csdec_pkg::KIND_CTRL;
            end
        end
        return d;
    endfunction

    function automatic logic [31:0] packMask(
        input csdec_pkg::csdec_cfg_t c
    );
        logic [31:0] v;
        v = `CSD_DATA_ZERO;
        v[`CSD_BLOCK_MASK_LSB +: 16] = c.blockMask;
        v[`CSD_WRITE_PROTECT_BIT] = c.writeProtect;
        v[`CSD_ALT_QUALIFY_BIT] = c.altQualify;
        v[`CSD_SPACE_LSB +: 5] = c.spaceMask;
        v[`CSD_VALID_BIT] = c.valid;
        return v;
    endfunction

    // status mirrors the registered outputs, never the raw matches
    function automatic logic [31:0] packStatus(
        input logic boot,
        input logic [2:0] selN,
        input logic abort
    );
        logic [31:0] s;
        s = `CSD_DATA_ZERO;
        s[`CSD_ST_BOOT_BIT] = boot;
        s[`CSD_ST_SEL_LSB +: 3] = ~selN;
        s[`CSD_ST_ABORT_BIT] = abort;
        return s;
    endfunction

    // ----------------------------------------
    // storage
    // ----------------------------------------
    // each field lives in its own array so every array has one writer
    logic [15:0] regionBase [NUM_SEL];
    logic [15:0] blockMask [NUM_SEL];
    logic writeProtect [NUM_SEL];
    logic altQualify [NUM_SEL];
    logic [4:0] spaceMask [NUM_SEL];
    logic selValid [NUM_SEL];
    logic [15:0] ctrl [NUM_SEL];
    csdec_pkg::csdec_cfg_t cfg [NUM_SEL];
    csdec_pkg::csdec_dec_t dec;
    logic wrTake;
    logic rdTake;
    logic wrBase;
    logic wrMask;
    logic wrCtrl;
    logic [31:0] baseMerged;
    logic [31:0] maskMerged;
    logic [31:0] ctrlMerged;
    logic [31:0] next_readdata;
    logic [NUM_SEL-1:0] hit;
    logic [NUM_SEL-1:0] protHit;

    assign dec = decodeAddr(avs_address);
    // a write lands at the edge where waitrequest is seen low
    assign wrTake = avs_write & ~avs_waitrequest;
    assign rdTake = avs_read & avs_waitrequest;
    assign wrBase = wrTake & dec.hit & (dec.kind == csdec_pkg::KIND_ADDR);
    assign wrMask = wrTake & dec.hit & (dec.kind == csdec_pkg::KIND_MASK);
    assign wrCtrl = wrTake & dec.hit & (dec.kind == csdec_pkg::KIND_CTRL);

    // ----------------------------------------
    // byte-lane merge of the addressed register
    // ----------------------------------------
    // unwritten lanes keep their old content
    assign baseMerged = mergeBytes({regionBase[dec.index], 16'h0000}, avs_writedata,
        avs_byteenable);
    assign maskMerged = mergeBytes(packMask(cfg[dec.index]), avs_writedata, avs_byteenable);
    assign ctrlMerged = mergeBytes({16'h0000, ctrl[dec.index]}, avs_writedata,
        avs_byteenable);

    // ----------------------------------------
    // configuration view handed to the matchers
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_SEL; i++) begin
            cfg[i].base = regionBase[i];
            cfg[i].blockMask = blockMask[i];
            cfg[i].writeProtect = writeProtect[i];
            cfg[i].altQualify = altQualify[i];
            cfg[i].spaceMask = spaceMask[i];
            cfg[i].valid = selValid[i];
        end
    end

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    // one wait cycle per access keeps readdata a clean flop output
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // ----------------------------------------
    // base address registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                regionBase[i] <= `CSD_BASE_RST;
            end
        end else if (wrBase) begin
            // only the upper half exists; low half reserved
            regionBase[dec.index] <= baseMerged[`CSD_BASE_LSB +: 16]; // R01 R16
        end
    end

    // ----------------------------------------
    // mask and qualifier registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                blockMask[i] <= `CSD_BLOCK_MASK_RST;
                writeProtect[i] <= 1'b0;
                altQualify[i] <= 1'b0;
                spaceMask[i] <= `CSD_SPACE_RST;
                selValid[i] <= 1'b0;
            end
        end else if (wrMask) begin
            blockMask[dec.index] <= maskMerged[`CSD_BLOCK_MASK_LSB +: 16]; // R04
            writeProtect[dec.index] <= maskMerged[`CSD_WRITE_PROTECT_BIT]; // R07
            altQualify[dec.index] <= maskMerged[`CSD_ALT_QUALIFY_BIT]; // R09 R10
            spaceMask[dec.index] <= maskMerged[`CSD_SPACE_LSB +: 5]; // R08
            if (dec.index == 2'h0) begin
                // no way back to boot mode short of reset
                selValid[0] <= selValid[0] | maskMerged[`CSD_VALID_BIT]; // R13
            end else begin
                selValid[dec.index] <= maskMerged[`CSD_VALID_BIT]; // R11
            end
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    // wait-state, sizing and burst fields are stored only
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                ctrl[i] <= `CSD_CTRL_RST;
            end
        end else if (wrCtrl) begin
            ctrl[dec.index] <= ctrlMerged[15:0]; // R16
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_comb begin
        next_readdata = `CSD_DATA_ZERO;
        if (dec.hit && dec.kind == csdec_pkg::KIND_ADDR) begin
            next_readdata[`CSD_BASE_LSB +: 16] = cfg[dec.index].base;
        end else if (dec.hit && dec.kind == csdec_pkg::KIND_MASK) begin
            next_readdata = packMask(cfg[dec.index]);
        end else if (dec.hit && dec.kind == csdec_pkg::KIND_CTRL) begin
            next_readdata[15:0] = ctrl[dec.index];
        end else if (avs_address == `CSD_REG_STATUS) begin
            next_readdata = packStatus(bootMode, {selectTwoN, selectOneN, selectZeroN},
                dataAbort);
        end
    end

    // unmapped reads return zero, unmapped writes vanish
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            avs_readdata <= `CSD_DATA_ZERO;
        end else if (rdTake) begin
            avs_readdata <= next_readdata;
        end
    end

    // ----------------------------------------
    // region match per select
    // ----------------------------------------
    for (genvar g = 0; g < NUM_SEL; g++) begin : gSel
        csdec_match #(
            .BOOT_CAPABLE(g == 0)
        ) uMatch (
            .cfg(cfg[g]),
            .zeroValid(cfg[0].valid), // R14
            .acc(accReq),
            .hit(hit[g]),
            .protHit(protHit[g])
        );
    end

    // ----------------------------------------
    // select outputs
    // ----------------------------------------
    // registered: selects follow the access by one cycle
    // overlapping regions may pull several selects low together
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            selectZeroN <= 1'b1;
            selectOneN <= 1'b1;
            selectTwoN <= 1'b1;
        end else begin
            selectZeroN <= ~hit[0]; // R17
            selectOneN <= ~hit[1]; // R17
            selectTwoN <= ~hit[2]; // R17
        end
    end

    // ----------------------------------------
    // abort and boot status
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            dataAbort <= 1'b0;
            bootMode <= 1'b1;
        end else begin
            // one pulse per protected write cycle, no sticky flag
            dataAbort <= |protHit; // R07
            bootMode <= ~cfg[0].valid; // R12
        end
    end

endmodule // csdec_top

// ===== verification/csdec_checker.sv
// port assertions for the chip-select decoder
`timescale 1ns/1ps
module csdec_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // access and selects
    input wire csdec_pkg::csdec_acc_t accReq,
    input wire logic selectZeroN,
    input wire logic selectOneN,
    input wire logic selectTwoN,
    input wire logic dataAbort,
    input wire logic bootMode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
    property p_bus; s_req |=> s_ans; endproperty
    property p_boot; bootMode && accReq.valid && !avs_write && !$past(avs_write)
        |=> !selectZeroN; endproperty
    property p_hold; bootMode && $past(bootMode) |-> selectOneN && selectTwoN; endproperty
    property p_sticky; !bootMode |=> !bootMode; endproperty
    property p_idle; !accReq.valid |=> selectZeroN && selectOneN && selectTwoN && !dataAbort;
    endproperty
    property p_abwr; dataAbort |-> $past(accReq.valid) && $past(accReq.write); endproperty
    property p_absel; dataAbort |-> !(selectZeroN && selectOneN && selectTwoN); endproperty
    property p_bootwp; bootMode && $past(bootMode) |-> !dataAbort; endproperty
    a_bus: assert property (p_bus) else $error("bus answer not one cycle");
    a_boot: assert property (p_boot) else $error("boot select missing");
    a_hold: assert property (p_hold) else $error("select before zero valid");
    a_sticky: assert property (p_sticky) else $error("zero valid cleared");
    a_idle: assert property (p_idle) else $error("select without access");
    a_abwr: assert property (p_abwr) else $error("abort without write");
    a_absel: assert property (p_absel) else $error("abort without hit");
    a_bootwp: assert property (p_bootwp) else $error("abort in boot mode");
endmodule // csdec_checker

// ===== verification/csdec_ext_mem.sv
// external device model counting select strobes
`timescale 1ns/1ps
module csdec_ext_mem (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // selects
    input wire logic selectZeroN,
    input wire logic selectOneN,
    input wire logic selectTwoN,
    // observed traffic
    output logic [15:0] strobes
);
    // a device only answers while its select is low
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            strobes <= 16'h0000;
        end else if (!(selectZeroN && selectOneN && selectTwoN)) begin
            strobes <= strobes + 16'h0001;
        end
    end
endmodule // csdec_ext_mem

// ===== verification/testbench.sv
// self-checking bench for the chip-select decoder
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [31:0] a;
        logic w;
        logic d;
        logic [4:0] sp;
        logic [3:0] exp;
    } csdec_row_t;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] avsAddress = 8'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0000_0000;
    logic [3:0] avsByteenable = 4'hF;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    csdec_pkg::csdec_acc_t accReq = '0;
    logic selectZeroN, selectOneN, selectTwoN, dataAbort, bootMode;
    logic [15:0] strobes;
    int nFail = 0;
    int nChecks = 0;
    int nHit = 0;
    // exp is {two, one, zero, abort}; base0 0 mask 0x2, base1 0x20 wp, base2 0x100 qualify
    csdec_row_t rows [15] = '{
        '{32'h0000_1234, 1'b0, 1'b0, 5'h01, 4'h2}, '{32'h0001_0000, 1'b0, 1'b0, 5'h01, 4'h0},
        '{32'h0002_FFFF, 1'b0, 1'b0, 5'h02, 4'h2}, '{32'h0020_0000, 1'b0, 1'b0, 5'h04, 4'h4},
        '{32'h0021_8000, 1'b0, 1'b0, 5'h04, 4'h4}, '{32'h0022_0000, 1'b0, 1'b0, 5'h04, 4'h0},
        '{32'h0020_0000, 1'b1, 1'b0, 5'h04, 4'h5}, '{32'h0020_0000, 1'b0, 1'b0, 5'h01, 4'h0},
        '{32'h0020_0000, 1'b0, 1'b1, 5'h01, 4'h4}, '{32'h0100_0000, 1'b0, 1'b0, 5'h08, 4'h0},
        '{32'h0100_0000, 1'b0, 1'b1, 5'h08, 4'h0}, '{32'h0100_0000, 1'b0, 1'b1, 5'h01, 4'h8},
        '{32'h0100_FFFF, 1'b1, 1'b0, 5'h10, 4'h8}, '{32'h0101_0000, 1'b0, 1'b0, 5'h01, 4'h0},
        '{32'h0000_0000, 1'b0, 1'b0, 5'h02, 4'h2}};
    always #2.5 sys_clk = ~sys_clk;
    csdec_top DUT (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
        .avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest),
        .accReq(accReq), .selectZeroN(selectZeroN), .selectOneN(selectOneN),
        .selectTwoN(selectTwoN), .dataAbort(dataAbort), .bootMode(bootMode));
    csdec_ext_mem mem (.sys_clk(sys_clk), .resetn(resetn), .selectZeroN(selectZeroN),
        .selectOneN(selectOneN), .selectTwoN(selectTwoN), .strobes(strobes));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", nChecks, nFail);
        if (nFail == 0 && nChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // request held until the edge that samples waitrequest low
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        @(posedge sys_clk);
        avsRead <= rd;
        avsWrite <= !rd;
        avsAddress <= a;
        avsWritedata <= wd;
        do @(posedge sys_clk); while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] q;
        bus(1'b0, a, wd, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b1, a, 32'h0000_0000, q);
        check(q, exp);
    endtask
    task automatic acc(input csdec_row_t r);
        @(posedge sys_clk);
        accReq <= '{1'b1, r.a, r.w, r.d, csdec_pkg::csdec_space_t'(r.sp)};
        @(posedge sys_clk);
        accReq.valid <= 1'b0;
        #1;
        check({~selectTwoN, ~selectOneN, ~selectZeroN, dataAbort}, r.exp);
        if (r.exp[3:1] != 3'h0) nHit++;
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge sys_clk);
        nFail++;
        results();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        #1;
        check({avsWaitrequest, selectZeroN, bootMode, dataAbort}, 4'hE);
        rd(8'h84, 32'h0000_0000);
        rd(8'hA4, 32'h0000_0001);
        $display("test reset done");
        acc('{32'h0020_0000, 1'b1, 1'b0, 5'h04, 4'h2});
        wr(8'h8C, 32'h0020_0000);
        wr(8'h90, 32'h0001_0103);
        acc('{32'h0020_0000, 1'b0, 1'b0, 5'h04, 4'h2});
        wr(8'h80, 32'h0000_0000);
        wr(8'h84, 32'h0002_0001);
        wr(8'h84, 32'h0002_0000);
        rd(8'h84, 32'h0002_0001);
        check(bootMode, 1'b0);
        wr(8'h98, 32'h0100_0000);
        wr(8'h9C, 32'h0000_0051);
        rd(8'h8C, 32'h0020_0000);
        rd(8'hB0, 32'h0000_0000);
        wr(8'h88, 32'hFFFF_1234);
        avsByteenable <= 4'h1;
        wr(8'h88, 32'h0000_00AB);
        avsByteenable <= 4'hF;
        rd(8'h88, 32'h0000_12AB);
        $display("test boot done");
        foreach (rows[i]) acc(rows[i]);
        wr(8'h9C, 32'h0000_0050);
        acc('{32'h0100_0000, 1'b0, 1'b1, 5'h01, 4'h0});
        wr(8'h9C, 32'h0000_0051);
        acc('{32'h0100_0000, 1'b0, 1'b1, 5'h01, 4'h8});
        repeat (2) @(posedge sys_clk);
        #1;
        check(strobes, nHit);
        $display("test decode done");
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        #1;
        check({avsWaitrequest, selectZeroN, bootMode, dataAbort}, 4'hE);
        rd(8'h84, 32'h0000_0000);
        rd(8'hA4, 32'h0000_0001);
        check(bootMode, 1'b1);
        $display("test second reset done");
        results();
    end
endmodule // testbench
bind csdec_top csdec_checker u_chk (.sys_clk(sys_clk), .resetn(resetn), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .accReq(accReq),
    .selectZeroN(selectZeroN), .selectOneN(selectOneN), .selectTwoN(selectTwoN),
    .dataAbort(dataAbort), .bootMode(bootMode));
